// file: rtl/obpc_map.svh
// Named offsets, field positions, codes and reset values of the option byte decoder.
`ifndef OBPC_MAP_SVH
`define OBPC_MAP_SVH

// Index of each option byte in the non-volatile option row.
`define OBPC_IDX_LOCK       2'h0
`define OBPC_IDX_BOOT       2'h1
`define OBPC_IDX_REMAP      2'h2
`define OBPC_IDX_CLKDOG     2'h3
`define OBPC_IDX_LAST       2'h3

// Code in the read-out lock byte that turns protection on.
`define OBPC_LOCK_CODE      8'hAA

// Boot area size decode: zero, largest exact size, and the saturated page count.
`define OBPC_BOOT_NONE      8'h00
`define OBPC_BOOT_MAX_EXACT 8'h7F
`define OBPC_BOOT_ALL_PAGES 8'h80

// Bit positions inside the clock and watchdog option byte.
`define OBPC_BIT_TRIM4      3'h4
`define OBPC_BIT_SLOW_OSC   3'h3
`define OBPC_BIT_IDOG_HW    3'h2
`define OBPC_BIT_WDOG_HW    3'h1
`define OBPC_BIT_WDOG_HALT  3'h0

// Reset value of every stored option byte.
`define OBPC_BYTE_RST       8'h00

`endif

// file: rtl/obpc_pkg.sv
// Types shared by the option byte decoder files.
package obpc_pkg;

  // Loader sequence, one-hot.
  typedef enum logic [2:0] {
    OBPC_ST_FETCH  = 3'b001,
    OBPC_ST_DECODE = 3'b010,
    OBPC_ST_DONE   = 3'b100
  } obpc_ld_state_t;

  // Decoded configuration, held from load until the next reset.
  typedef struct packed {
    logic       readout_locked;
    logic [7:0] boot_pages;
    logic [7:0] pin_function_remap;
    logic       fast_osc_trim_width;
    logic       slow_osc_cpu_allow;
    logic       indep_dog_hw_start;
    logic       window_dog_hw_start;
    logic       window_dog_halt_reset;
  } obpc_cfg_t;

endpackage : obpc_pkg

// file: rtl/obpc_opt_store.sv
// Small register store that shadows the option bytes read from non-volatile memory.
`timescale 1ns/1ns
`default_nettype none
`include "obpc_map.svh"

module obpc_opt_store
  import obpc_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
)
(
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Write port.
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Every entry, straight from its flip-flops.
  output var  logic [DEPTH*WIDTH-1:0]   rd_all
);

  // Width of an entry index.
  localparam int IDX_W = $clog2(DEPTH);

  // Storage words, one element per entry so that each has its own writer.
  logic [WIDTH-1:0] mem [DEPTH];

  // One storage word per entry, each updated only when addressed.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          mem[g] <= WIDTH'(`OBPC_BYTE_RST);
        end
        else if (wr_en && (wr_idx == IDX_W'(g)))
        begin
          mem[g] <= wr_data;
        end
      end
      // The flat view is a plain copy of the word flip-flops.
      assign rd_all[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate

endmodule // obpc_opt_store
`default_nettype wire

// file: rtl/obpc_top.sv
// Option byte loader and decoder for memory protection, clock and watchdog configuration.
// Functional notes
// - Lock byte 0xAA means read-out protection on.
// - Protection blocks debug and programming memory access.
// - Changing active protection triggers global memory erase.
// - Boot size zero: no boot area, unprotected.
// - Size n up to 127: pages below n protected.
// - Size above 127: pages 0 to 127 protected.
// - Unlock keys never open the boot area.
// - Main memory is flash outside the boot area.
// - Trim option selects 3-bit or 4-bit trim field.
// - Slow oscillator option allows it as CPU clock.
// - Independent watchdog option selects hardware start.
// - Window watchdog option selects hardware start.
// - Halt reset option resets on halt when active.
`timescale 1ns/1ns
`default_nettype none
`include "obpc_map.svh"

module obpc_top
  import obpc_pkg::*;
#(
  parameter int OPT_BYTES = 4,
  parameter int PAGE_BITS = 7
)
(
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Option row fetch from the non-volatile array.
  output logic                      nv_rd_req,
  output logic [1:0]                nv_rd_idx,
  input  wire logic                 nv_rd_valid,
  input  wire logic [7:0]           nv_rd_data,
  // Debug or in-circuit programming access to flash and data memory.
  input  wire logic                 dbg_mem_req,
  output logic                      dbg_mem_grant,
  output logic                      dbg_mem_refuse,
  // Option byte write requests arriving over the debug link.
  input  wire logic                 opt_wr_req,
  input  wire logic [1:0]           opt_wr_idx,
  input  wire logic [7:0]           opt_wr_data,
  output logic                      opt_wr_accept,
  output logic                      global_erase,
  // In-application programming page writes.
  input  wire logic                 iap_wr_req,
  input  wire logic [PAGE_BITS-1:0] iap_wr_page,
  input  wire logic                 main_memory_unlock_keys,
  output logic                      iap_wr_grant,
  // Halt handling for the window watchdog.
  input  wire logic                 halt_enter,
  input  wire logic                 window_dog_active,
  output logic                      halt_reset_req,
  // Decoded configuration.
  output obpc_cfg_t                 opt_cfg,
  output logic                      cfg_valid
);

  // Loader state and its next value.
  obpc_ld_state_t           ld_state;
  obpc_ld_state_t           next_ld_state;
  // Index of the option byte now being fetched.
  logic [1:0]               fetch_idx;
  // All shadowed option bytes, flat.
  logic [OPT_BYTES*8-1:0]   store_all;
  // Byte views of the store.
  logic [7:0]               lock_byte;
  logic [7:0]               boot_byte;
  logic [7:0]               remap_byte;
  logic [7:0]               clkdog_byte;
  // Page compare and lock-toggle helpers.
  logic                     page_in_boot;
  logic                     lock_toggle;
  logic                     loaded;

  // The store keeps the raw bytes; it is written only while fetching.
  obpc_opt_store #(
    .DEPTH   (OPT_BYTES),
    .WIDTH   (8)
  ) u_store (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (nv_rd_req && nv_rd_valid),
    .wr_idx   (fetch_idx),
    .wr_data  (nv_rd_data),
    .rd_all   (store_all)
  );

  // Slice the flat store into the four option bytes.
  assign lock_byte   = store_all[8*`OBPC_IDX_LOCK   +: 8];
  assign boot_byte   = store_all[8*`OBPC_IDX_BOOT   +: 8];
  assign remap_byte  = store_all[8*`OBPC_IDX_REMAP  +: 8];
  assign clkdog_byte = store_all[8*`OBPC_IDX_CLKDOG +: 8];

  // Configuration is usable only once the loader has finished.
  // Grants and accepts all wait on this, so nothing passes before the decode.
  assign loaded    = (ld_state == OBPC_ST_DONE);
  assign cfg_valid = loaded;

  // Loader sequencing: fetch each byte in turn, decode once, then hold.
  always_comb
  begin
    next_ld_state = ld_state;
    case (ld_state)
      OBPC_ST_FETCH:
      begin
        // Leave after the last byte has been returned.
        if (nv_rd_valid && (fetch_idx == `OBPC_IDX_LAST))
        begin
          next_ld_state = OBPC_ST_DECODE;
        end
      end
      OBPC_ST_DECODE:
      begin
        // One spare cycle lets the last stored byte reach the decode.
        next_ld_state = OBPC_ST_DONE;
      end
      OBPC_ST_DONE:
      begin
        // Held until the next reset.
        next_ld_state = OBPC_ST_DONE;
      end
      default:
      begin
        // An illegal state code restarts the fetch.
        next_ld_state = OBPC_ST_FETCH;
      end
    endcase
  end

  // State register of the loader; starts fetching right after reset release.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ld_state <= OBPC_ST_FETCH;
    end
    else
    begin
      ld_state <= next_ld_state;
    end
  end

  // Fetch index advances on each returned byte.
  // It wraps to zero after the last byte, when the loader has already left.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fetch_idx <= `OBPC_IDX_LOCK;
    end
    else if ((ld_state == OBPC_ST_FETCH) && nv_rd_valid)
    begin
      fetch_idx <= fetch_idx + 2'h1;
    end
  end

  // Request stays up while fetching; the index names the byte.
  assign nv_rd_req = (ld_state == OBPC_ST_FETCH);
  assign nv_rd_idx = fetch_idx;

  // Decoded configuration, captured once in the decode step.
  // Before that it shows the safest values: locked and fully protected.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      opt_cfg.readout_locked        <= 1'b1;
      opt_cfg.boot_pages            <= `OBPC_BOOT_ALL_PAGES;
      opt_cfg.pin_function_remap    <= `OBPC_BYTE_RST;
      opt_cfg.fast_osc_trim_width   <= 1'b0;
      opt_cfg.slow_osc_cpu_allow    <= 1'b0;
      opt_cfg.indep_dog_hw_start    <= 1'b0;
      opt_cfg.window_dog_hw_start   <= 1'b0;
      opt_cfg.window_dog_halt_reset <= 1'b0;
    end
    else if (ld_state == OBPC_ST_DECODE)
    begin
      opt_cfg.readout_locked <= (lock_byte == `OBPC_LOCK_CODE);
      if (boot_byte > `OBPC_BOOT_MAX_EXACT)
      begin
        opt_cfg.boot_pages <= `OBPC_BOOT_ALL_PAGES;
      end
      else
      begin
        opt_cfg.boot_pages <= boot_byte;
      end
      opt_cfg.pin_function_remap    <= remap_byte;
      opt_cfg.fast_osc_trim_width   <= clkdog_byte[`OBPC_BIT_TRIM4];
      opt_cfg.slow_osc_cpu_allow    <= clkdog_byte[`OBPC_BIT_SLOW_OSC];
      opt_cfg.indep_dog_hw_start    <= clkdog_byte[`OBPC_BIT_IDOG_HW];
      opt_cfg.window_dog_hw_start   <= clkdog_byte[`OBPC_BIT_WDOG_HW];
      opt_cfg.window_dog_halt_reset <= clkdog_byte[`OBPC_BIT_WDOG_HALT];
    end
  end

  // Debug memory access is granted only when loaded and unlocked.
  assign dbg_mem_grant  = dbg_mem_req && loaded && !opt_cfg.readout_locked;
  assign dbg_mem_refuse = dbg_mem_req && !dbg_mem_grant;

  // A lock byte write that would change the protection state.
  // Writing the enable code while locked changes nothing and so erases nothing.
  assign lock_toggle = opt_wr_req && (opt_wr_idx == `OBPC_IDX_LOCK)
                       && ((opt_wr_data == `OBPC_LOCK_CODE) != opt_cfg.readout_locked);

  // While locked only the lock byte may be written; any value but the lock code erases.
  assign opt_wr_accept = opt_wr_req && loaded
                         && (!opt_cfg.readout_locked || (opt_wr_idx == `OBPC_IDX_LOCK));

  // One-cycle erase pulse after a toggle attempt on an active lock.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      global_erase <= 1'b0;
    end
    else
    begin
      global_erase <= loaded && opt_cfg.readout_locked && lock_toggle;
    end
  end

  // A page lies in the boot area when it is below the boot page count.
  // The page is widened by one bit so that the saturated count covers page 127.
  assign page_in_boot = ({1'b0, iap_wr_page} < opt_cfg.boot_pages);

  // Application writes need the unlock keys and a main-memory page.
  assign iap_wr_grant = iap_wr_req && loaded && main_memory_unlock_keys && !page_in_boot;

  // Halt reset request, one cycle after halt entry with the dog active.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      halt_reset_req <= 1'b0;
    end
    else
    begin
      halt_reset_req <= loaded && halt_enter && window_dog_active
                        && opt_cfg.window_dog_halt_reset;
    end
  end

  // Checks on the decoded behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Lock byte decode and the protection it enforces.
  a_lock_decode: assert property ((ld_state == OBPC_ST_DECODE) |=>
      (opt_cfg.readout_locked == ($past(lock_byte) == `OBPC_LOCK_CODE)))
    else $error("lock decode wrong");
  a_dbg_block: assert property ((dbg_mem_req && opt_cfg.readout_locked) |->
      (!dbg_mem_grant && dbg_mem_refuse))
    else $error("debug access passed while locked");
  a_accept_lock: assert property ((opt_wr_req && opt_cfg.readout_locked
      && (opt_wr_idx != `OBPC_IDX_LOCK)) |-> !opt_wr_accept)
    else $error("option write accepted while locked");
  a_erase_toggle: assert property ((loaded && opt_cfg.readout_locked && opt_wr_req
      && (opt_wr_idx == `OBPC_IDX_LOCK) && (opt_wr_data != `OBPC_LOCK_CODE)) |=> global_erase)
    else $error("no erase on lock toggle");
  a_erase_cause: assert property (global_erase
      |-> $past(opt_cfg.readout_locked && opt_wr_req && (opt_wr_idx == `OBPC_IDX_LOCK)))
    else $error("erase without cause");

  // Boot area size decode and the page write gate.
  a_boot_none: assert property (((ld_state == OBPC_ST_DECODE) && (boot_byte == `OBPC_BOOT_NONE))
      |=> (opt_cfg.boot_pages == `OBPC_BOOT_NONE))
    else $error("zero boot size not kept");
  a_boot_cap: assert property (((ld_state == OBPC_ST_DECODE) && boot_byte[7])
      |=> (opt_cfg.boot_pages == `OBPC_BOOT_ALL_PAGES))
    else $error("boot size not saturated");
  a_boot_protect: assert property ((iap_wr_req && ({1'b0, iap_wr_page} < opt_cfg.boot_pages))
      |-> !iap_wr_grant)
    else $error("boot page write granted");
  a_keys_needed: assert property ((iap_wr_req && !main_memory_unlock_keys) |-> !iap_wr_grant)
    else $error("page write granted without keys");
  a_main_write: assert property ((iap_wr_req && loaded && main_memory_unlock_keys
      && ({1'b0, iap_wr_page} >= opt_cfg.boot_pages)) |-> iap_wr_grant)
    else $error("main page write refused");

  // Halt reset, load sequence and the held configuration.
  a_halt_reset: assert property ((loaded && halt_enter && window_dog_active) |=>
      (halt_reset_req == opt_cfg.window_dog_halt_reset))
    else $error("halt reset mismatch");
  a_cfg_hold: assert property (loaded |=> $stable(opt_cfg))
    else $error("configuration changed after load");
  a_load_time: assert property ((nv_rd_req && nv_rd_valid && (nv_rd_idx == `OBPC_IDX_LAST))
      |-> ##1 (!nv_rd_req && !cfg_valid) ##1 cfg_valid)
    else $error("load did not finish");
  a_idle_refuse: assert property (!loaded |-> (!dbg_mem_grant && !iap_wr_grant && !opt_wr_accept))
    else $error("access granted before load");

  // Main scenarios worth seeing at least once.
  c_load_done: cover property ($rose(cfg_valid));
  c_erase: cover property (global_erase);
  c_boot_block: cover property (iap_wr_req && page_in_boot && main_memory_unlock_keys);
  c_halt_reset: cover property (halt_reset_req);
  c_locked_refuse: cover property (opt_wr_req && loaded && !opt_wr_accept);

endmodule // obpc_top
`default_nettype wire

// file: bench/obpc_nv_model.sv
// Behavioural option row store that answers the loader's fetch requests.
`timescale 1ns/1ns
`default_nettype none

module obpc_nv_model
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Fetch port facing the loader.
  input  wire logic        nv_rd_req,
  input  wire logic [1:0]  nv_rd_idx,
  output var  logic        nv_rd_valid,
  output var  logic [7:0]  nv_rd_data,
  // Stored option row and answer pace.
  input  wire logic [31:0] row,
  input  wire logic        slow
);
  // Byte the loader currently addresses.
  logic [7:0] cur;

  assign cur = row[8*nv_rd_idx +: 8];

  // Valid follows the request; in slow mode it drops every other cycle.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      nv_rd_valid <= 1'b0;
    else
      nv_rd_valid <= nv_rd_req && !(slow && nv_rd_valid);
  end

  // Outside a valid cycle the lines show the inverse, so no stale byte passes.
  assign nv_rd_data = nv_rd_valid ? cur : ~cur;
endmodule // obpc_nv_model
`default_nettype wire

// file: bench/test_obpc_top.sv
// Self-checking bench for the option byte loader and decoder.
`timescale 1ns/1ns
`default_nettype none

module test_obpc_top
  import obpc_pkg::*;
();
  // Stimulus, all given a value at time zero.
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       slow = 1'b0;
  logic       dbg_mem_req = 1'b0;
  logic       opt_wr_req = 1'b0;
  logic       iap_wr_req = 1'b0;
  logic       main_memory_unlock_keys = 1'b0;
  logic       halt_enter = 1'b0;
  logic       window_dog_active = 1'b0;
  logic [1:0] opt_wr_idx = 2'h0;
  logic [7:0] opt_wr_data = 8'h00;
  logic [6:0] iap_wr_page = 7'h00;
  logic [31:0] nv_row = 32'h0;
  // Design outputs and fetch port.
  logic       nv_rd_req, nv_rd_valid, dbg_mem_grant, dbg_mem_refuse, opt_wr_accept;
  logic       global_erase, iap_wr_grant, halt_reset_req, cfg_valid;
  logic [1:0] nv_rd_idx;
  logic [7:0] nv_rd_data;
  obpc_cfg_t  opt_cfg;
  // Counters of comparisons and mismatches.
  int         err_count = 0;
  int         num_checks = 0;

  // One row: option row {clock/dog, remap, boot size, lock} and expected decode.
  typedef struct packed {
    logic [31:0] opt;
    logic        lk;
    logic [7:0]  pg;
    logic [4:0]  bits;
  } obpc_row_t;

  // Ordinary cases: lock code, boot size bounds and every option bit.
  obpc_row_t rows [5] = '{
    '{32'h1F5A00AA, 1'b1, 8'h00, 5'h1F},
    '{32'h00A50155, 1'b0, 8'h01, 5'h00},
    '{32'h15007FAB, 1'b0, 8'h7F, 5'h15},
    '{32'hEAFF8000, 1'b0, 8'h80, 5'h0A},
    '{32'h0B3CFFA9, 1'b0, 8'h80, 5'h0B}
  };

  // Clock of 10 ns period.
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // Design under test and its option row store.
  obpc_top i_dut (
    .core_clk, .rst_b, .nv_rd_req, .nv_rd_idx, .nv_rd_valid, .nv_rd_data,
    .dbg_mem_req, .dbg_mem_grant, .dbg_mem_refuse,
    .opt_wr_req, .opt_wr_idx, .opt_wr_data, .opt_wr_accept, .global_erase,
    .iap_wr_req, .iap_wr_page, .main_memory_unlock_keys, .iap_wr_grant,
    .halt_enter, .window_dog_active, .halt_reset_req, .opt_cfg, .cfg_valid
  );
  obpc_nv_model i_nv (
    .core_clk, .rst_b, .nv_rd_req, .nv_rd_idx, .nv_rd_valid, .nv_rd_data,
    .row(nv_row), .slow
  );

  // Compares one result against its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Resets for 12 cycles with one row stored, then waits for the decode.
  task automatic load(input int r);
    int n;
    n = 0;
    @(negedge core_clk);
    nv_row = rows[r].opt;
    slow = r[0];
    rst_b = 1'b0;
    dbg_mem_req = 1'b1;
    repeat (12) @(negedge core_clk);
    chk({cfg_valid, nv_rd_req, nv_rd_idx, opt_cfg.readout_locked, opt_cfg.boot_pages}, 13'h0980);
    chk({dbg_mem_grant, dbg_mem_refuse}, 2'h1);
    rst_b = 1'b1;
    dbg_mem_req = 1'b0;
    while (cfg_valid !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 40)
    begin
      err_count++;
      stop_test();
    end
    chk(nv_rd_req, 1'b0);
  endtask

  // Attempts one option byte write and checks accept and the erase pulse.
  task automatic owr(input logic [1:0] i, input logic [7:0] d, input logic acc, input logic ers);
    @(negedge core_clk);
    opt_wr_req = 1'b1;
    opt_wr_idx = i;
    opt_wr_data = d;
    #1;
    chk(opt_wr_accept, acc);
    @(negedge core_clk);
    opt_wr_req = 1'b0;
    chk(global_erase, ers);
  endtask

  // Row loop first, then the hand-written protection cases.
  initial
  begin
    for (int r = 0; r < 5; r++)
    begin
      load(r);
      chk(opt_cfg, {rows[r].lk, rows[r].pg, rows[r].opt[23:16], rows[r].bits});
      dbg_mem_req = 1'b1;
      #1;
      chk({dbg_mem_grant, dbg_mem_refuse}, {!rows[r].lk, rows[r].lk});
      @(negedge core_clk);
      dbg_mem_req = 1'b0;
      iap_wr_req = 1'b1;
      main_memory_unlock_keys = 1'b1;
      iap_wr_page = rows[r].pg[6:0] - 7'h01;
      #1;
      chk(iap_wr_grant, rows[r].pg == 8'h00);
      @(negedge core_clk);
      iap_wr_page = rows[r].pg[6:0];
      halt_enter = 1'b1;
      window_dog_active = 1'b1;
      #1;
      chk(iap_wr_grant, rows[r].pg < 8'h80);
      @(negedge core_clk);
      iap_wr_req = 1'b0;
      halt_enter = 1'b0;
      chk(halt_reset_req, rows[r].bits[0]);
      $display("Row %0d done", r);
    end
    owr(2'h2, 8'h11, 1'b1, 1'b0);
    owr(2'h0, 8'hAA, 1'b1, 1'b0);
    $display("Unlocked writes done");
    load(0);
    owr(2'h1, 8'h00, 1'b0, 1'b0);
    owr(2'h0, 8'h00, 1'b1, 1'b1);
    owr(2'h0, 8'hAA, 1'b1, 1'b0);
    chk(opt_cfg, {1'b1, 8'h00, 8'h5A, 5'h1F});
    window_dog_active = 1'b0;
    halt_enter = 1'b1;
    @(negedge core_clk);
    halt_enter = 1'b0;
    chk(halt_reset_req, 1'b0);
    main_memory_unlock_keys = 1'b0;
    iap_wr_req = 1'b1;
    iap_wr_page = 7'h7F;
    #1;
    chk(iap_wr_grant, 1'b0);
    @(negedge core_clk);
    iap_wr_req = 1'b0;
    $display("Locked writes and halt done");
    stop_test();
  end
endmodule // test_obpc_top
`default_nettype wire
